// >>> cpm_params.svh
// Constants for the current and power monitor core
`ifndef CPM_PARAMS_SVH
`define CPM_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register pointer offsets
// ----------------------------------------------------------------------------
`define CPM_PTR_CONFIG      8'h00
`define CPM_PTR_SHUNT       8'h01
`define CPM_PTR_BUS         8'h02
`define CPM_PTR_POWER       8'h03
`define CPM_PTR_CURRENT     8'h04
`define CPM_PTR_CAL         8'h05

// ----------------------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------------------
`define CPM_CONFIG_RESET    16'h0000
`define CPM_CAL_RESET       16'h0000
`define CPM_ZERO16          16'h0000
`define CPM_BUS_SIGN_BIT    15
`define CPM_ADDR_PREFIX     3'h4

// ----------------------------------------------------------------------------
// Arithmetic scaling
// ----------------------------------------------------------------------------
`define CPM_CURRENT_DIV     2048
`define CPM_POWER_DIV       20000

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CPM_TIMEOUT_US      28000
`define CPM_CLK_KHZ         25000
`define CPM_BITS_PER_BYTE   4'h8

`endif

// >>> cpm_pkg.sv
// Types shared by the current and power monitor core
package cpm_pkg;

    typedef enum logic [3:0] {
        CPM_IDLE,
        CPM_ADDR,
        CPM_ADDR_ACK,
        CPM_PTR,
        CPM_PTR_ACK,
        CPM_WDATA,
        CPM_WDATA_ACK,
        CPM_RDATA,
        CPM_RACK
    } cpm_state_t;

    typedef logic [15:0] cpm_word_t;

endpackage

// >>> cpm_calc.sv
// Current and power result engine
`timescale 1ns/1ps
`include "cpm_params.svh"

module cpm_calc (
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    input  wire logic              sample_valid,
    input  wire cpm_pkg::cpm_word_t shunt_code,
    input  wire cpm_pkg::cpm_word_t bus_code,
    input  wire cpm_pkg::cpm_word_t cal_value,
    input  wire logic              cal_valid,
    output cpm_pkg::cpm_word_t     current_out,
    output cpm_pkg::cpm_word_t     power_out
);
    import cpm_pkg::*;

    // ------------------------------------------------------------------------
    // Arithmetic
    // ------------------------------------------------------------------------
    localparam logic signed [32:0] CUR_DIV = 33'(`CPM_CURRENT_DIV);
    localparam logic signed [32:0] PWR_DIV = 33'(`CPM_POWER_DIV);

    logic signed [32:0] cur_prod;
    logic signed [32:0] cur_quot;
    logic signed [15:0] cur_now;
    logic signed [32:0] pwr_prod;
    logic signed [32:0] pwr_quot;

    // Signed divide truncates toward zero, fraction dropped
    always_comb begin
        cur_prod = $signed(shunt_code) * $signed({1'b0, cal_value});      // see (RQ1)
        cur_quot = cur_prod / CUR_DIV;                                     // see (RQ25)
        cur_now  = cur_quot[15:0];
        pwr_prod = cur_now * $signed({1'b0, bus_code});                    // see (RQ2)
        pwr_quot = pwr_prod / PWR_DIV;                                     // see (RQ7)
    end

    // ------------------------------------------------------------------------
    // Result registers
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            current_out <= `CPM_ZERO16;
            power_out   <= `CPM_ZERO16;
        end else if (!cal_valid) begin
            current_out <= `CPM_ZERO16;                                    // see (RQ6)
            power_out   <= `CPM_ZERO16;                                    // see (RQ5)
        end else if (sample_valid) begin
            current_out <= cur_now;
            power_out   <= pwr_quot[15:0];
        end
    end

endmodule // cpm_calc

// >>> cpm_monitor.sv
// Serial target and register bank of the current and power monitor
`timescale 1ns/1ps
`include "cpm_params.svh"

// Contract
// (RQ1) Current is shunt code times cal over 2048
// (RQ2) Power is current times bus code over 20000
// (RQ3) Bus code reported at fixed weight
// (RQ4) Bus result top bit always zero
// (RQ5) Current and power derive from calibration
// (RQ6) Results stay zero until calibration written
// (RQ7) Power weight is 25 current steps
// (RQ8) Raw voltages update continuously from reset
// (RQ9) All registers return to defaults at reset
// (RQ10) Software may rescale calibration for system error
// (RQ11) Both bus lines open drain only
// (RQ12) Controller makes clock, start and stop
// (RQ13) Start is SDA fall while SCL high
// (RQ14) Address sampled on SCL rise, last bit direction
// (RQ15) Acknowledge matching address on ninth clock
// (RQ16) Eight data bits then receiver acknowledge
// (RQ17) SDA change in SCL high is start/stop
// (RQ18) Stop is SDA rise while SCL high
// (RQ19) Abandon stalled transfer after 28 ms
// (RQ20) Address byte is seven bits plus direction
// (RQ21) Straps decode to sixteen addresses
// (RQ22) High strap on data/clock gives upper eight
// (RQ23) Straps resampled on every transaction
// (RQ24) Words move high byte first
// (RQ25) Integer division, two's complement results
module cpm_monitor #(
    parameter int TIMEOUT_CYCLES = (`CPM_TIMEOUT_US * `CPM_CLK_KHZ) / 1000,
    parameter int TO_W           = 20
) (
    input  wire logic               sys_clk,
    input  wire logic               reset_n,
    input  wire logic               scl_in,
    output logic                    scl_out,
    output logic                    scl_oe,
    input  wire logic               sda_in,
    output logic                    sda_out,
    output logic                    sda_oe,
    input  wire logic [1:0]         addr_strap_high,
    input  wire logic [1:0]         addr_strap_low,
    input  wire logic               sample_valid,
    input  wire cpm_pkg::cpm_word_t shunt_code,
    input  wire cpm_pkg::cpm_word_t supply_sense_pin,
    output cpm_pkg::cpm_word_t      config_value,
    output logic                    cal_valid
);
    import cpm_pkg::*;

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    // Strap codes: 0 ground, 1 supply, 2 data line, 3 clock line
    function automatic logic [6:0] strap_addr(input logic [1:0] hi, input logic [1:0] lo);
        strap_addr = {`CPM_ADDR_PREFIX, hi, lo};                           // see (RQ21) (RQ22)
    endfunction

    function automatic logic [7:0] byte_of(input cpm_word_t w, input logic lsb);
        byte_of = lsb ? w[7:0] : w[15:8];                                  // see (RQ24)
    endfunction

    // ------------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------------
    logic rst_s1;
    logic rst_n;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n  <= rst_s1;
        end
    end

    // ------------------------------------------------------------------------
    // Line synchronisers and condition detect
    // ------------------------------------------------------------------------
    logic scl_s1;
    logic scl_s2;
    logic scl_d;
    logic sda_s1;
    logic sda_s2;
    logic sda_d;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_d  <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_d  <= 1'b1;
        end else begin
            scl_s1 <= scl_in;
            scl_s2 <= scl_s1;
            scl_d  <= scl_s2;
            sda_s1 <= sda_in;
            sda_s2 <= sda_s1;
            sda_d  <= sda_s2;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    // SDA moving with SCL high is never data
    assign scl_rise  = scl_s2 & ~scl_d;                                    // see (RQ14)
    assign scl_fall  = ~scl_s2 & scl_d;
    assign start_det = scl_s2 & scl_d & sda_d & ~sda_s2;                   // see (RQ13) (RQ17)
    assign stop_det  = scl_s2 & scl_d & ~sda_d & sda_s2;                   // see (RQ18) (RQ17)

    // ------------------------------------------------------------------------
    // Register bank storage
    // ------------------------------------------------------------------------
    cpm_word_t shunt_reg;
    cpm_word_t bus_reg;
    cpm_word_t config_reg;
    cpm_word_t cal_reg;
    logic      cal_valid_reg;
    cpm_word_t current_val;
    cpm_word_t power_val;

    // Raw codes follow every conversion, no setup needed
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            shunt_reg <= `CPM_ZERO16;
            bus_reg   <= `CPM_ZERO16;
        end else if (sample_valid) begin
            shunt_reg <= shunt_code;                                       // see (RQ8)
            bus_reg   <= supply_sense_pin;                                 // see (RQ3)
        end
    end

    cpm_calc u_calc (
        .sys_clk      (sys_clk),
        .rst_n        (rst_n),
        .sample_valid (sample_valid),
        .shunt_code   (shunt_reg),
        .bus_code     (bus_reg),
        .cal_value    (cal_reg),
        .cal_valid    (cal_valid_reg),
        .current_out  (current_val),
        .power_out    (power_val)
    );

    // ------------------------------------------------------------------------
    // Serial target state
    // ------------------------------------------------------------------------
    cpm_state_t      state_reg;
    logic [3:0]      bit_cnt_reg;
    logic [7:0]      shift_reg;
    logic [7:0]      tx_reg;
    logic [7:0]      ptr_reg;
    logic [7:0]      data_hi_reg;
    logic            byte_sel_reg;
    logic            rw_reg;
    logic            nack_reg;
    logic [6:0]      my_addr_reg;
    logic            sda_oe_reg;
    logic [TO_W-1:0] to_cnt_reg;
    logic            timeout;
    logic            wr_strobe;
    logic [7:0]      rx_byte;
    logic [7:0]      rd_first;
    logic [7:0]      rd_next;

    localparam logic [TO_W-1:0] TO_LIMIT = TO_W'(TIMEOUT_CYCLES);

    assign rx_byte   = {shift_reg[6:0], sda_s2};
    assign timeout   = (to_cnt_reg == TO_LIMIT);
    assign wr_strobe = (state_reg == CPM_WDATA) && scl_fall
                       && (bit_cnt_reg == `CPM_BITS_PER_BYTE) && byte_sel_reg;

    // Read mux; unmapped pointers read zero
    function automatic cpm_word_t reg_read(input logic [7:0] p);
        case (p)
            `CPM_PTR_CONFIG:  reg_read = config_reg;
            `CPM_PTR_SHUNT:   reg_read = shunt_reg;
            `CPM_PTR_BUS: begin
                reg_read = bus_reg;
                reg_read[`CPM_BUS_SIGN_BIT] = 1'b0;                        // see (RQ4)
            end
            `CPM_PTR_POWER:   reg_read = power_val;
            `CPM_PTR_CURRENT: reg_read = current_val;
            `CPM_PTR_CAL:     reg_read = cal_reg;
            default:          reg_read = `CPM_ZERO16;
        endcase
    endfunction

    assign rd_first = byte_of(reg_read(ptr_reg), 1'b0);
    assign rd_next  = byte_of(reg_read(ptr_reg), ~byte_sel_reg);

    // Stall guard: counts while busy, any SCL edge restarts it
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            to_cnt_reg <= '0;
        end else if (state_reg == CPM_IDLE || scl_rise || scl_fall || timeout) begin
            to_cnt_reg <= '0;
        end else begin
            to_cnt_reg <= to_cnt_reg + 1'b1;                               // see (RQ19)
        end
    end

    // Straps are caught at each start, so late strap moves are ignored
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            my_addr_reg <= '0;
        end else if (start_det) begin
            my_addr_reg <= strap_addr(addr_strap_high, addr_strap_low);    // see (RQ23)
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg    <= CPM_IDLE;
            bit_cnt_reg  <= '0;
            shift_reg    <= '0;
            tx_reg       <= '0;
            data_hi_reg  <= '0;
            byte_sel_reg <= 1'b0;
            rw_reg       <= 1'b0;
            nack_reg     <= 1'b0;
            sda_oe_reg   <= 1'b0;
        end else if (start_det) begin
            state_reg    <= CPM_ADDR;
            bit_cnt_reg  <= '0;
            byte_sel_reg <= 1'b0;
            sda_oe_reg   <= 1'b0;
        end else if (stop_det || timeout) begin
            state_reg  <= CPM_IDLE;                                        // see (RQ19)
            sda_oe_reg <= 1'b0;
        end else begin
            case (state_reg)
                CPM_ADDR, CPM_PTR, CPM_WDATA: begin
                    if (scl_rise) begin
                        shift_reg   <= rx_byte;                            // see (RQ14)
                        bit_cnt_reg <= bit_cnt_reg + 1'b1;
                    end else if (scl_fall && bit_cnt_reg == `CPM_BITS_PER_BYTE) begin
                        bit_cnt_reg <= '0;
                        sda_oe_reg  <= 1'b1;                               // see (RQ16)
                        if (state_reg == CPM_ADDR) begin
                            rw_reg <= shift_reg[0];                        // see (RQ20)
                            if (shift_reg[7:1] == my_addr_reg) begin
                                state_reg <= CPM_ADDR_ACK;                 // see (RQ15)
                            end else begin
                                state_reg  <= CPM_IDLE;
                                sda_oe_reg <= 1'b0;
                            end
                        end else if (state_reg == CPM_PTR) begin
                            state_reg <= CPM_PTR_ACK;
                        end else begin
                            data_hi_reg  <= shift_reg;                     // see (RQ24)
                            byte_sel_reg <= ~byte_sel_reg;
                            state_reg    <= CPM_WDATA_ACK;
                        end
                    end
                end
                CPM_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (rw_reg) begin
                            tx_reg     <= rd_first;
                            sda_oe_reg <= ~rd_first[7];                    // see (RQ11)
                            nack_reg   <= 1'b0;
                            state_reg  <= CPM_RDATA;
                        end else begin
                            sda_oe_reg <= 1'b0;
                            state_reg  <= CPM_PTR;
                        end
                    end
                end
                CPM_PTR_ACK, CPM_WDATA_ACK: begin
                    if (scl_fall) begin
                        sda_oe_reg <= 1'b0;
                        state_reg  <= CPM_WDATA;
                    end
                end
                CPM_RDATA: begin
                    if (scl_rise) begin
                        bit_cnt_reg <= bit_cnt_reg + 1'b1;
                    end else if (scl_fall) begin
                        if (bit_cnt_reg == `CPM_BITS_PER_BYTE) begin
                            bit_cnt_reg <= '0;
                            sda_oe_reg  <= 1'b0;                           // see (RQ16)
                            state_reg   <= CPM_RACK;
                        end else begin
                            tx_reg     <= {tx_reg[6:0], 1'b0};
                            sda_oe_reg <= ~tx_reg[6];
                        end
                    end
                end
                CPM_RACK: begin
                    if (scl_rise) begin
                        nack_reg <= sda_s2;
                    end else if (scl_fall) begin
                        if (nack_reg) begin
                            state_reg <= CPM_IDLE;
                        end else begin
                            // Further reads alternate low, high of same word
                            tx_reg       <= rd_next;
                            sda_oe_reg   <= ~rd_next[7];
                            byte_sel_reg <= ~byte_sel_reg;
                            state_reg    <= CPM_RDATA;
                        end
                    end
                end
                default: begin
                    state_reg  <= CPM_IDLE;
                    sda_oe_reg <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Pointer and writable registers
    // ------------------------------------------------------------------------
    // Pointer survives reads, so repeat reads need no pointer byte
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr_reg <= `CPM_PTR_CONFIG;
        end else if (state_reg == CPM_PTR && scl_fall
                     && bit_cnt_reg == `CPM_BITS_PER_BYTE) begin
            ptr_reg <= shift_reg;
        end
    end

    // Defaults return on every reset; nothing is retained
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            config_reg    <= `CPM_CONFIG_RESET;                            // see (RQ9)
            cal_reg       <= `CPM_CAL_RESET;
            cal_valid_reg <= 1'b0;                                         // see (RQ6)
        end else if (wr_strobe) begin
            if (ptr_reg == `CPM_PTR_CONFIG) begin
                config_reg <= {data_hi_reg, shift_reg};                    // see (RQ24)
            end
            if (ptr_reg == `CPM_PTR_CAL) begin
                cal_reg       <= {data_hi_reg, shift_reg};                 // see (RQ5)
                cal_valid_reg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Pins
    // ------------------------------------------------------------------------
    // Lines only ever pulled low; clock is never held
    assign sda_out      = 1'b0;                                            // see (RQ11)
    assign sda_oe       = sda_oe_reg;
    assign scl_out      = 1'b0;
    assign scl_oe       = 1'b0;                                            // see (RQ12)
    assign config_value = config_reg;
    assign cal_valid    = cal_valid_reg;

endmodule // cpm_monitor

// >>> cpm_monitor_sva.sv
// Port checker for the monitor core
`timescale 1ns/1ps
module cpm_monitor_sva #(
    parameter int TIMEOUT_CYCLES = 700000
) (
    input wire logic        sys_clk,
    input wire logic        reset_n,
    input wire logic        scl_in,
    input wire logic        scl_out,
    input wire logic        scl_oe,
    input wire logic        sda_in,
    input wire logic        sda_out,
    input wire logic        sda_oe,
    input wire logic [1:0]  addr_strap_high,
    input wire logic [1:0]  addr_strap_low,
    input wire logic        sample_valid,
    input wire logic [15:0] shunt_code,
    input wire logic [15:0] supply_sense_pin,
    input wire logic [15:0] config_value,
    input wire logic        cal_valid
);
    import cpm_pkg::*;
    logic        scl_q;
    logic [31:0] quiet_cnt;
    // ----------------------------------------------------------------
    // Cycles since the clock line last moved
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_q     <= 1'b1;
            quiet_cnt <= 32'h0;
        end else begin
            scl_q <= scl_in;
            if (scl_q != scl_in)
                quiet_cnt <= 32'h0;
            else if (quiet_cnt < 32'(TIMEOUT_CYCLES + 8))
                quiet_cnt <= quiet_cnt + 32'h1;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    AST_SCL_NEVER: assert property (!scl_oe && !scl_out)
        else $error("clock line driven");
    AST_SDA_OPEN_DRAIN: assert property (!sda_out)
        else $error("data line driven high");
    AST_RESET_DEFAULTS: assert property ($rose(reset_n) |-> !cal_valid && config_value == 16'h0000)
        else $error("not at defaults");
    AST_CAL_STAYS: assert property (cal_valid |=> cal_valid)
        else $error("calibration flag lost");
    AST_SDA_EDGE_LOW: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data moved with clock high");
    AST_TIMEOUT: assert property (quiet_cnt >= 32'(TIMEOUT_CYCLES + 8) |-> !sda_oe)
        else $error("bus held after timeout");
    AST_CFG_ON_FALL: assert property ($changed(config_value) |-> !scl_in)
        else $error("config set off clock low");
    AST_CAL_ON_FALL: assert property ($rose(cal_valid) |-> !scl_in)
        else $error("cal set off clock low");
    cover property ($rose(cal_valid));
    cover property ($rose(sda_oe));
    cover property ($changed(config_value));
    cover property (quiet_cnt == 32'(TIMEOUT_CYCLES));
endmodule // cpm_monitor_sva

bind cpm_monitor cpm_monitor_sva #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_sva (.*);

// >>> cpm_i2c_ctrl.sv
// Two-wire bus controller model
`timescale 1ns/1ps
module cpm_i2c_ctrl (
    output logic      scl_low,
    output logic      sda_low,
    input  wire logic sda_line
);
    // ----------------------------------------------------------------
    // Bus conditions and bits
    // ----------------------------------------------------------------
    initial begin
        {scl_low, sda_low} = 2'b00;
    end
    // Start, SDA falls with SCL high
    task start_cond();
        #40 sda_low = 1'b0;
        #120 scl_low = 1'b0;
        #120 sda_low = 1'b1;
        #120 scl_low = 1'b1;
    endtask
    // Stop, SDA rises while SCL high
    task stop_cond();
        #40 sda_low = 1'b1;
        #120 scl_low = 1'b0;
        #120 sda_low = 1'b0;
        #120;
    endtask
    // SDA moves only with SCL low
    task xfer_bit(input logic b, output logic r);
        #40 sda_low = ~b;
        #160 scl_low = 1'b0;
        #80 r = sda_line;
        #40 scl_low = 1'b1;
    endtask
    // Eight bits MSB first, then acknowledge
    task wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) xfer_bit(d[i], r);
        xfer_bit(1'b1, r);
        ack = ~r;
    endtask
    task rd_byte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(1'b1, r);
            d[i] = r;
        end
        xfer_bit(~ack, r);
    endtask
endmodule // cpm_i2c_ctrl

// >>> tb_top.sv
// Self-checking bench for the monitor core
`timescale 1ns/1ps
module tb_top;
    import cpm_pkg::*;
    logic      sys_clk, reset_n, sample_valid, scl_oe, scl_o, sda_oe, sda_o, cal_valid;
    logic      c_scl_low, c_sda_low, ack;
    logic [1:0] strap_hi, strap_lo;
    logic [6:0] addr7;
    cpm_word_t shunt, supply, cfg_val, rd;
    int        err_total, n_checks;
    wire logic scl_line = ~((scl_oe & ~scl_o) | c_scl_low);
    wire logic sda_line = ~((sda_oe & ~sda_o) | c_sda_low);
    // Shunt, bus, cal, current, power
    logic [15:0] rows [5][5] = '{
        '{16'h1F40, 16'h2570, 16'h0A00, 16'h2710, 16'h12B8},
        '{16'hE0C0, 16'h2570, 16'h0A00, 16'hD8F0, 16'hED48},
        '{16'h1F40, 16'h2570, 16'h09FD, 16'h2704, 16'h12B2}, // Rescaled
        '{16'h7FFF, 16'h4E20, 16'h0800, 16'h7FFF, 16'h7FFF},
        '{16'h0001, 16'h0001, 16'h07FF, 16'h0000, 16'h0000}};
    cpm_monitor #(.TIMEOUT_CYCLES(200), .TO_W(10)) dut (
        .sys_clk(sys_clk), .reset_n(reset_n), .scl_in(scl_line), .scl_out(scl_o),
        .scl_oe(scl_oe), .sda_in(sda_line), .sda_out(sda_o), .sda_oe(sda_oe),
        .addr_strap_high(strap_hi), .addr_strap_low(strap_lo), .sample_valid(sample_valid),
        .shunt_code(shunt), .supply_sense_pin(supply), .config_value(cfg_val),
        .cal_valid(cal_valid));
    cpm_i2c_ctrl ctrl (.scl_low(c_scl_low), .sda_low(c_sda_low), .sda_line(sda_line));
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task chk16(string what, logic [15:0] exp, logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task chk1(string what, logic exp, logic got);
        chk16(what, 16'(exp), 16'(got));
    endtask
    task wr_reg(logic [7:0] ptr, logic [15:0] val);
        logic a0, a1, a2, a3;
        ctrl.start_cond();
        ctrl.wr_byte({addr7, 1'b0}, a0);
        ctrl.wr_byte(ptr, a1);
        ctrl.wr_byte(val[15:8], a2);
        ctrl.wr_byte(val[7:0], a3);
        ctrl.stop_cond();
        chk1("write acks", 1'b1, a0 & a1 & a2 & a3);
    endtask
    task rd_reg(logic [7:0] ptr, output logic [15:0] val);
        logic a0, a1, a2;
        ctrl.start_cond();
        ctrl.wr_byte({addr7, 1'b0}, a0);
        ctrl.wr_byte(ptr, a1);
        ctrl.start_cond();
        ctrl.wr_byte({addr7, 1'b1}, a2);
        ctrl.rd_byte(1'b1, val[15:8]);
        ctrl.rd_byte(1'b0, val[7:0]);
        ctrl.stop_cond();
        chk1("read acks", 1'b1, a0 & a1 & a2);
    endtask
    task sample_twice(logic [15:0] s, logic [15:0] b);
        @(negedge sys_clk);
        shunt = s;
        supply = b;
        repeat (2) begin
            @(negedge sys_clk) sample_valid = 1'b1;
            @(negedge sys_clk) sample_valid = 1'b0;
        end
    endtask
    task give_verdict();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    initial begin
        #2000000;
        err_total++;
        give_verdict();
    end
    initial begin
        {reset_n, sample_valid, strap_hi, strap_lo, err_total, n_checks} = '0;
        {shunt, supply, addr7} = {16'h0, 16'h0, 7'h40};
        repeat (16) @(negedge sys_clk);
        reset_n = 1'b1;
        repeat (8) @(negedge sys_clk);
        for (int i = 0; i < 5; i++) begin
            wr_reg(8'h05, rows[i][2]);
            sample_twice(rows[i][0], rows[i][1]);
            rd_reg(8'h04, rd);
            chk16("current", rows[i][3], rd);
            rd_reg(8'h03, rd);
            chk16("power", rows[i][4], rd);
            rd_reg(8'h02, rd);
            chk16("bus", rows[i][1], rd);
            rd_reg(8'h01, rd);
            chk16("shunt", rows[i][0], rd);
        end
        wr_reg(8'h00, 16'h4127);
        chk16("config port", 16'h4127, cfg_val);
        rd_reg(8'h00, rd);
        chk16("config", 16'h4127, rd);
        wr_reg(8'h02, 16'h1234);
        rd_reg(8'h02, rd);
        chk16("bus read-only", 16'h0001, rd);
        rd_reg(8'h07, rd);
        chk16("unmapped", 16'h0000, rd);
        sample_twice(16'h0000, 16'hFFFF);
        rd_reg(8'h02, rd);
        chk16("bus top bit", 16'h7FFF, rd);
        for (int a = 0; a < 16; a++) begin
            @(negedge sys_clk);
            {strap_hi, strap_lo} = 4'(a);
            addr7 = {3'b100, strap_hi, strap_lo};
            ctrl.start_cond();
            ctrl.wr_byte({addr7, 1'b0}, ack);
            ctrl.stop_cond();
            chk1("strap ack", 1'b1, ack);
        end
        ctrl.start_cond();
        ctrl.wr_byte(8'h80, ack);
        ctrl.stop_cond();
        chk1("old address", 1'b0, ack);
        // Stall mid-read
        ctrl.start_cond();
        ctrl.wr_byte({addr7, 1'b1}, ack);
        repeat (6) @(negedge sys_clk);
        chk1("read drive", 1'b1, sda_oe);
        repeat (230) @(negedge sys_clk);
        chk1("timeout release", 1'b0, sda_oe);
        ctrl.stop_cond();
        @(negedge sys_clk) reset_n = 1'b0;
        repeat (16) @(negedge sys_clk);
        reset_n = 1'b1;
        chk1("cal after reset", 1'b0, cal_valid);
        chk16("config after reset", 16'h0000, cfg_val);
        repeat (8) @(negedge sys_clk);
        sample_twice(16'h1F40, 16'h2570);
        rd_reg(8'h04, rd);
        chk16("current uncal", 16'h0000, rd);
        rd_reg(8'h01, rd);
        chk16("shunt uncal", 16'h1F40, rd);
        give_verdict();
    end
endmodule // tb_top
